// >>> hw/lcct_pkg.sv
// package: link control register map, field positions and cycle timer constants
package lcct_pkg;
  localparam logic [7:0]  LINK_CTRL_SET_OFF = 8'he0;
  localparam logic [7:0]  LINK_CTRL_CLR_OFF = 8'he4;
  localparam int          ROLLOVER_SRC_BIT  = 22;
  localparam int          CYCLE_MASTER_BIT  = 21;
  localparam int          COUNT_EN_BIT      = 20;
  localparam int          ACCEPT_PHY_BIT    = 10;
  localparam int          ACCEPT_SELFID_BIT = 9;
  localparam logic [31:0] LINK_CTRL_MASK    = 32'h0070_0600;
  localparam logic [31:0] LINK_CTRL_RESET   = 32'h0000_0000;
  localparam int          CYCLE_PERIODS     = 3072;
  localparam int          OFFSET_W          = 12;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;
endpackage : lcct_pkg

// >>> hw/lcct_top.sv
// link control register with set and clear views, driving the cycle offset timer
`timescale 1ns/1ps
module lcct_top #(
  parameter int OFFSET_W = lcct_pkg::OFFSET_W
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                clk_en,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                cycle_tick,
  input  wire logic                external_cycle_input,
  input  wire logic                cycle_overrun_flag,
  input  wire logic                rx_cycle_start,
  input  wire logic                rx_phy_packet,
  input  wire logic                rx_selfid_packet,
  input  wire logic                ar_request_enabled,
  output      logic [OFFSET_W-1:0] cycle_offset,
  output      logic                cycle_rollover,
  output      logic                cycle_start_tx,
  output      logic                cycle_sync_load,
  output      logic                store_phy_packet,
  output      logic                store_selfid_packet,
  output      logic                rollover_source_select,
  output      logic                root_cycle_master,
  output      logic                cycle_count_enable,
  output      logic                accept_phy_packets,
  output      logic                accept_selfid_packets
);

  typedef struct packed {
    logic                aw_held;
    logic [7:0]          awaddr;
    logic                w_held;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [31:0]         ctrl;
    logic [OFFSET_W-1:0] offset;
    logic                ext_prev;
    logic                ovr_prev;
    logic                rollover;
    logic                cstart;
    logic                sync;
    logic                store_phy;
    logic                store_sid;
  } lcct_state_type;

  lcct_state_type st_r;
  lcct_state_type st_nxt;

  logic [31:0] wmask;
  logic        wr_fire;
  logic        rd_fire;
  logic        ext_event;
  logic        ovr_rise;
  logic        roll;

  // no address or write data handshake completes while frozen, or the transfer would be lost
  assign s_axi_awready = clk_en && !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready  = clk_en && !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = clk_en && !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  assign rollover_source_select = st_r.ctrl[lcct_pkg::ROLLOVER_SRC_BIT];
  assign root_cycle_master      = st_r.ctrl[lcct_pkg::CYCLE_MASTER_BIT];
  assign cycle_count_enable     = st_r.ctrl[lcct_pkg::COUNT_EN_BIT];
  assign accept_phy_packets     = st_r.ctrl[lcct_pkg::ACCEPT_PHY_BIT];
  assign accept_selfid_packets  = st_r.ctrl[lcct_pkg::ACCEPT_SELFID_BIT];
  assign cycle_offset           = st_r.offset;
  assign cycle_rollover         = st_r.rollover;
  assign cycle_start_tx         = st_r.cstart;
  assign cycle_sync_load        = st_r.sync;
  assign store_phy_packet       = st_r.store_phy;
  assign store_selfid_packet    = st_r.store_sid;

  always_comb begin
    st_nxt  = st_r;
    wmask   = 32'h0000_0000;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    // address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      wr_fire        = 1'b1;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      for (int i = 0; i < 4; i++) begin
        wmask[i*8 +: 8] = st_r.wdata[i*8 +: 8] & {8{st_r.wstrb[i]}};
      end
      wmask = wmask & lcct_pkg::LINK_CTRL_MASK;
      if (st_r.awaddr[7:2] == lcct_pkg::LINK_CTRL_SET_OFF[7:2]) begin
        st_nxt.bresp = lcct_pkg::RESP_OKAY;
        if (cycle_overrun_flag) begin
          wmask[lcct_pkg::CYCLE_MASTER_BIT] = 1'b0;
        end
        st_nxt.ctrl = st_r.ctrl | wmask;
      end else if (st_r.awaddr[7:2] == lcct_pkg::LINK_CTRL_CLR_OFF[7:2]) begin
        st_nxt.bresp = lcct_pkg::RESP_OKAY;
        st_nxt.ctrl  = st_r.ctrl & ~wmask;
      end else begin
        st_nxt.bresp = lcct_pkg::RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_fire       = 1'b1;
      st_nxt.rvalid = 1'b1;
      if (s_axi_araddr[7:2] == lcct_pkg::LINK_CTRL_SET_OFF[7:2] ||
          s_axi_araddr[7:2] == lcct_pkg::LINK_CTRL_CLR_OFF[7:2]) begin
        st_nxt.rdata = st_r.ctrl & lcct_pkg::LINK_CTRL_MASK;
        st_nxt.rresp = lcct_pkg::RESP_OKAY;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rresp = lcct_pkg::RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // overrun rising edge wins over any set of the master bit
    ovr_rise = cycle_overrun_flag && !st_r.ovr_prev;
    if (ovr_rise) begin
      st_nxt.ctrl[lcct_pkg::CYCLE_MASTER_BIT] = 1'b0;
    end
    st_nxt.ovr_prev = cycle_overrun_flag;
    // cycle timer
    ext_event       = external_cycle_input && !st_r.ext_prev;
    st_nxt.ext_prev = external_cycle_input;
    roll            = 1'b0;
    if (rollover_source_select) begin
      roll = ext_event && cycle_count_enable;
    end else begin
      roll = cycle_count_enable && cycle_tick &&
             (st_r.offset == OFFSET_W'(lcct_pkg::CYCLE_PERIODS - 1));
    end
    if (cycle_count_enable) begin
      if (roll) begin
        st_nxt.offset = '0;
      end else if (cycle_tick) begin
        st_nxt.offset = st_r.offset + OFFSET_W'(1);
      end
    end // else hold
    st_nxt.rollover  = roll;
    st_nxt.cstart    = roll && root_cycle_master;
    st_nxt.sync      = rx_cycle_start && !root_cycle_master;
    st_nxt.store_phy = rx_phy_packet && accept_phy_packets && ar_request_enabled;
    st_nxt.store_sid = rx_selfid_packet && accept_selfid_packets;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  chk_set_view_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_r.ctrl[lcct_pkg::COUNT_EN_BIT]) |-> $past(st_r.awaddr) == lcct_pkg::LINK_CTRL_SET_OFF)
    else $error("count enable rose without set view write");
  chk_clear_view_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(st_r.ctrl[lcct_pkg::COUNT_EN_BIT]) |-> $past(st_r.awaddr) == lcct_pkg::LINK_CTRL_CLR_OFF)
    else $error("count enable fell without clear view write");
  chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> (s_axi_rdata & ~lcct_pkg::LINK_CTRL_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  chk_master_overrun: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cycle_overrun_flag && !st_r.ovr_prev |=> !root_cycle_master)
    else $error("cycle master not cleared on overrun");
  chk_master_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cycle_overrun_flag && !root_cycle_master |=> !root_cycle_master)
    else $error("cycle master set during overrun");
  chk_hold_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !cycle_count_enable |=> $stable(cycle_offset))
    else $error("offset moved while disabled");
  chk_int_rollover: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_rollover && $past(clk_en) && !$past(rollover_source_select) |->
      $past(cycle_offset) == OFFSET_W'(lcct_pkg::CYCLE_PERIODS - 1))
    else $error("internal rollover at wrong count");
  chk_start_master: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_start_tx |-> cycle_rollover && $past(root_cycle_master))
    else $error("cycle start without master rollover");
  chk_phy_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    store_phy_packet |-> $past(accept_phy_packets) && $past(ar_request_enabled))
    else $error("phy packet stored while not accepted");

  // rollover source and counting
  chk_ext_rollover: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rollover_source_select && cycle_count_enable &&
    external_cycle_input && !st_r.ext_prev |=> cycle_rollover)
    else $error("external cycle event did not roll over");

  chk_ext_only: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_rollover && $past(clk_en) && $past(rollover_source_select) |->
      $past(external_cycle_input) && !$past(st_r.ext_prev))
    else $error("external source rolled over without event");

  chk_count_advance: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && cycle_count_enable && cycle_tick && !rollover_source_select &&
    cycle_offset != OFFSET_W'(lcct_pkg::CYCLE_PERIODS - 1) |=>
      cycle_offset == $past(cycle_offset) + OFFSET_W'(1))
    else $error("offset did not advance while enabled");

  chk_freeze_state: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> $stable(cycle_offset) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("state moved while clock enable low");

  // cycle start synchronisation and receive gating
  chk_sync_slave: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rx_cycle_start && !root_cycle_master |=> cycle_sync_load)
    else $error("received cycle start not used while not master");

  chk_sync_master: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_sync_load |-> !$past(root_cycle_master))
    else $error("cycle sync loaded while master");

  chk_selfid_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rx_selfid_packet && accept_selfid_packets |=> store_selfid_packet)
    else $error("self-id packet not accepted");

  chk_selfid_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    store_selfid_packet |-> $past(accept_selfid_packets))
    else $error("self-id packet stored while not accepted");

  chk_phy_indep: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && rx_selfid_packet && accept_selfid_packets && !accept_phy_packets |=>
      store_selfid_packet)
    else $error("self-id reception depends on phy accept");

  // register bus responses
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");

  chk_read_views: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr == lcct_pkg::LINK_CTRL_SET_OFF || s_axi_araddr == lcct_pkg::LINK_CTRL_CLR_OFF) |=>
      s_axi_rresp == lcct_pkg::RESP_OKAY &&
      s_axi_rdata[lcct_pkg::ACCEPT_PHY_BIT] == $past(accept_phy_packets))
    else $error("view read did not return register contents");

  chk_unmapped_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_fire && st_r.awaddr[7:2] != lcct_pkg::LINK_CTRL_SET_OFF[7:2] &&
    st_r.awaddr[7:2] != lcct_pkg::LINK_CTRL_CLR_OFF[7:2] |=>
      s_axi_bresp == lcct_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  cov_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire);
  cov_read: cover property (@(posedge aclk) disable iff (!aresetn) rd_fire);
  cov_roll: cover property (@(posedge aclk) disable iff (!aresetn) cycle_start_tx);
  cov_ext: cover property (@(posedge aclk) disable iff (!aresetn)
    cycle_rollover && rollover_source_select);
  cov_sync: cover property (@(posedge aclk) disable iff (!aresetn) cycle_sync_load);

endmodule : lcct_top

// >>> verif/tb_top.sv
// self-checking bench for the link control register and cycle timer
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cycle_tick, ovf;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, stim;
  logic [1:0]  bresp, rresp;
  logic [11:0] offset;
  logic [4:0]  mon;
  int          error_cnt, samples_checked, pc[5], cyc, last_ro, gap_ro, n, b, c;
  logic [11:0] held;
  logic        ce, are;
  logic [4:0]  lvl;

  lcct_top DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cycle_tick(cycle_tick), .external_cycle_input(stim[3]), .cycle_overrun_flag(ovf),
    .rx_cycle_start(stim[2]), .rx_phy_packet(stim[1]), .rx_selfid_packet(stim[0]),
    .ar_request_enabled(are), .cycle_offset(offset), .cycle_rollover(mon[4]),
    .cycle_start_tx(mon[3]), .cycle_sync_load(mon[2]), .store_phy_packet(mon[1]),
    .store_selfid_packet(mon[0]), .rollover_source_select(lvl[4]),
    .root_cycle_master(lvl[3]), .cycle_count_enable(lvl[2]),
    .accept_phy_packets(lvl[1]), .accept_selfid_packets(lvl[0]));

  always #4 aclk = ~aclk;

  // pulse counters and rollover spacing, sampled where outputs are settled
  always @(negedge aclk) begin
    cyc++;
    for (int i = 0; i < 5; i++) if (mon[i] === 1'b1) pc[i]++;
    if (mon[4] === 1'b1) begin
      gap_ro = cyc - last_ro;
      last_ro = cyc;
    end
  end

  task tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task hang(input string nm);
    error_cnt++;
    $display("[FAIL] %s expected response seen none", nm);
    tally_and_finish();
  endtask : hang

  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid; r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang("bvalid");
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ah = arvalid && arready;
      if (rvalid === 1'b1) begin
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) hang("rvalid");
  endtask : axi_rd

  // one-cycle pulse on a stimulus line, then count pulses on one output
  task pulse_chk(input string nm, input int si, input int mi, input int inc);
    b = pc[mi];
    @(posedge aclk) stim[si] <= 1'b1;
    @(posedge aclk) stim[si] <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(nm, inc, pc[mi] - b);
  endtask : pulse_chk

  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; cycle_tick = 1; ovf = 0; stim = 0;
    ce = 1; are = 1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'he0, 32'h0, lcct_pkg::RESP_OKAY);
    axi_wr(8'he0, 32'hffff_ffff, lcct_pkg::RESP_OKAY);
    axi_rd(8'he0, 32'h0070_0600, lcct_pkg::RESP_OKAY);
    axi_rd(8'he4, 32'h0070_0600, lcct_pkg::RESP_OKAY);
    axi_wr(8'he4, 32'h0040_0000, lcct_pkg::RESP_OKAY);
    axi_wr(8'he0, 32'h0, lcct_pkg::RESP_OKAY);
    axi_wr(8'he4, 32'h0, lcct_pkg::RESP_OKAY);
    axi_rd(8'he0, 32'h0030_0600, lcct_pkg::RESP_OKAY);
    axi_wr(8'h10, 32'hffff_ffff, lcct_pkg::RESP_SLVERR);
    axi_rd(8'h10, 32'h0, lcct_pkg::RESP_SLVERR);
    axi_rd(8'he4, 32'h0030_0600, lcct_pkg::RESP_OKAY);
    // internal rollover spacing with counting enabled and master on
    b = pc[4]; c = pc[3];
    for (n = 0; n < 8000 && pc[4] < b + 2; n++) @(posedge aclk);
    if (n == 8000) hang("rollover");
    repeat (3) @(posedge aclk);
    chk("rollover_gap", lcct_pkg::CYCLE_PERIODS, gap_ro);
    chk("cycle_start_count", 2, pc[3] - c);
    axi_wr(8'he4, 32'h0010_0000, lcct_pkg::RESP_OKAY);
    @(negedge aclk) held = offset;
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk("offset_hold", {20'h0, held}, {20'h0, offset});
    axi_wr(8'he0, 32'h0050_0000, lcct_pkg::RESP_OKAY);
    pulse_chk("ext_rollover", 3, 4, 1);
    // clock enable low freezes the running offset
    @(posedge aclk) ce <= 1'b0;
    @(negedge aclk) held = offset;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk("offset_freeze", {20'h0, held}, {20'h0, offset});
    @(posedge aclk) ce <= 1'b1;
    @(posedge aclk) ovf <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(8'he0, 32'h0050_0600, lcct_pkg::RESP_OKAY);
    axi_wr(8'he0, 32'h0020_0000, lcct_pkg::RESP_OKAY);
    axi_rd(8'he0, 32'h0050_0600, lcct_pkg::RESP_OKAY);
    @(posedge aclk) ovf <= 1'b0;
    axi_wr(8'he0, 32'h0020_0000, lcct_pkg::RESP_OKAY);
    axi_rd(8'he4, 32'h0070_0600, lcct_pkg::RESP_OKAY);
    chk("ctrl_levels", 32'h1f, {27'h0, lvl});
    axi_wr(8'he4, 32'h0020_0000, lcct_pkg::RESP_OKAY);
    pulse_chk("sync_load", 2, 2, 1);
    @(posedge aclk) are <= 1'b0;
    pulse_chk("store_phy_noctx", 1, 1, 0);
    @(posedge aclk) are <= 1'b1;
    pulse_chk("store_phy_on", 1, 1, 1);
    axi_wr(8'he4, 32'h0000_0400, lcct_pkg::RESP_OKAY);
    pulse_chk("store_selfid", 0, 0, 1);
    pulse_chk("store_phy_off", 1, 1, 0);
    axi_wr(8'he4, 32'h0000_0200, lcct_pkg::RESP_OKAY);
    pulse_chk("store_selfid_off", 0, 0, 0);
    tally_and_finish();
  end
endmodule : tb_top
